// *** rtl/cacm_pkg.sv ***
package cacm_pkg;

   // ****************************************************************
   // register addresses
   // ****************************************************************
   localparam logic [7:0] CTRL_ADDR = 8'hd8;
   localparam logic [7:0] MODE_ADDR = 8'hd9;

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int CTRL_OVF_BIT  = 7;
   localparam int CTRL_RUN_BIT  = 6;
   localparam int CTRL_MOD2_BIT = 2;
   localparam int MODE_IDLE_BIT = 7;
   localparam int MODE_WDE_BIT  = 6;
   localparam int MODE_LCK_BIT  = 5;
   localparam int MODE_TB_LSB   = 1;
   localparam int MODE_IEN_BIT  = 0;

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] MODE_RESET = 8'h40;
   localparam logic [7:0] RDATA_NONE = 8'h00;

   // ****************************************************************
   // timing counts
   // ****************************************************************
   localparam logic [3:0] DIV12_LAST = 4'hb;
   localparam logic [1:0] DIV4_LAST  = 2'h3;
   localparam logic [2:0] DIV8_LAST  = 3'h7;
   localparam logic [15:0] CNT_MAX   = 16'hffff;

   // ****************************************************************
   // timebase sources
   // ****************************************************************
   typedef enum logic [2:0] {
      TB_SYS_DIV12 = 3'h0,
      TB_SYS_DIV4  = 3'h1,
      TB_TMR0_OVF  = 3'h2,
      TB_EXT_FALL  = 3'h3,
      TB_SYS       = 3'h4,
      TB_EXT_DIV8  = 3'h5
   } cacm_tb_t;

   typedef struct packed {
      logic       ovf;
      logic       run;
      logic [2:0] rsv;
      logic [2:0] mod_flag;
   } cacm_ctrl_t;

   typedef struct packed {
      logic       idle_suspend;
      logic       wd_enable;
      logic       wd_lock;
      logic       rsv;
      logic [2:0] timebase;
      logic       ovf_irq_en;
   } cacm_mode_t;

endpackage

// *** rtl/cacm_tick_gen.sv ***
`timescale 1ns/100ps
module cacm_tick_gen (
   input  wire logic       mclk_i,
   input  wire logic       rst_n_i,
   input  wire logic [2:0] timebase_select_i,
   input  wire logic       run_i,
   input  wire logic       timer0_ovf_i,
   input  wire logic       external_count_input_i,
   input  wire logic       ext_clk_i,
   output logic            tick_o
);

   logic [1:0] eci_sync_ff;
   logic [1:0] xck_sync_ff;
   logic       eci_last_ff;
   logic       xck_last_ff;
   logic [3:0] div12_ff;
   logic [1:0] div4_ff;
   logic [2:0] div8_ff;
   logic [3:0] nxt_div12;
   logic [1:0] nxt_div4;
   logic [2:0] nxt_div8;
   logic       eci_fall;
   logic       xck_rise;

   // ****************************************************************
   // pin synchronisers and edge detect on the second stage only
   // ****************************************************************
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         eci_sync_ff <= 2'h3;
         xck_sync_ff <= 2'h0;
         eci_last_ff <= 1'b1;
         xck_last_ff <= 1'b0;
         div12_ff    <= 4'h0;
         div4_ff     <= 2'h0;
         div8_ff     <= 3'h0;
      end else begin
         eci_sync_ff <= {eci_sync_ff[0], external_count_input_i};
         xck_sync_ff <= {xck_sync_ff[0], ext_clk_i};
         eci_last_ff <= eci_sync_ff[1];
         xck_last_ff <= xck_sync_ff[1];
         div12_ff    <= nxt_div12;
         div4_ff     <= nxt_div4;
         div8_ff     <= nxt_div8;
      end
   end

   always_comb begin
      eci_fall  = eci_last_ff & ~eci_sync_ff[1];
      xck_rise  = ~xck_last_ff & xck_sync_ff[1];
      // dividers freeze with the counter so a resume does not lose phase
      nxt_div12 = div12_ff;
      nxt_div4  = div4_ff;
      nxt_div8  = div8_ff;
      if (run_i) begin
         nxt_div12 = (div12_ff == cacm_pkg::DIV12_LAST) ? 4'h0 : div12_ff + 4'h1;
         nxt_div4  = div4_ff + 2'h1;
         if (xck_rise) begin
            nxt_div8 = div8_ff + 3'h1;
         end
      end
      case (cacm_pkg::cacm_tb_t'(timebase_select_i))
         cacm_pkg::TB_SYS_DIV12: tick_o = (div12_ff == cacm_pkg::DIV12_LAST);
         cacm_pkg::TB_SYS_DIV4:  tick_o = (div4_ff == cacm_pkg::DIV4_LAST);
         cacm_pkg::TB_TMR0_OVF:  tick_o = timer0_ovf_i;
         cacm_pkg::TB_EXT_FALL:  tick_o = eci_fall;
         cacm_pkg::TB_SYS:       tick_o = 1'b1;
         cacm_pkg::TB_EXT_DIV8:  tick_o = xck_rise && (div8_ff == cacm_pkg::DIV8_LAST);
         default:                tick_o = 1'b0;
      endcase
   end

endmodule

// *** rtl/cacm_top.sv ***
`timescale 1ns/100ps
module cacm_top (
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   input  wire logic [7:0]  sfr_addr_i,
   input  wire logic        sfr_wr_i,
   input  wire logic        sfr_rd_i,
   input  wire logic [7:0]  sfr_wdata_i,
   output logic      [7:0]  sfr_rdata_o,
   input  wire logic        cpu_idle_i,
   input  wire logic        timer0_ovf_i,
   input  wire logic        external_count_input_i,
   input  wire logic        ext_clk_i,
   input  wire logic [2:0]  module_event_i,
   input  wire logic [2:0]  module_irq_enable_i,
   output logic             irq_o,
   output logic             watchdog_reset_o,
   output logic             module2_watchdog_o,
   output logic             counter_active_o,
   output logic             counter_tick_o,
   output logic      [15:0] count_o
);

   // ****************************************************************
   // reset release
   // ****************************************************************
   logic [1:0] rst_sync_ff;
   logic       rst_n;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_ff[1];

   // ****************************************************************
   // state
   // ****************************************************************
   cacm_pkg::cacm_ctrl_t ctrl_ff;
   cacm_pkg::cacm_ctrl_t nxt_ctrl;
   cacm_pkg::cacm_mode_t mode_ff;
   cacm_pkg::cacm_mode_t nxt_mode;
   logic [15:0]          count_ff;
   logic [15:0]          nxt_count;
   logic [7:0]           rdata_ff;
   logic [7:0]           nxt_rdata;
   logic                 wdrst_ff;
   logic                 nxt_wdrst;

   logic                 wr_ctrl;
   logic                 wr_mode;
   logic                 run;
   logic                 suspend;
   logic                 active;
   logic                 tick;
   logic                 step;
   cacm_pkg::cacm_ctrl_t wctrl;
   cacm_pkg::cacm_mode_t wmode;

   // ****************************************************************
   // timebase
   // ****************************************************************
   cacm_tick_gen u_tick (
      .mclk_i                 (mclk_i),
      .rst_n_i                (rst_n),
      .timebase_select_i      (mode_ff.timebase),
      .run_i                  (active),
      .timer0_ovf_i           (timer0_ovf_i),
      .external_count_input_i (external_count_input_i),
      .ext_clk_i              (ext_clk_i),
      .tick_o                 (tick)
   );

   // ****************************************************************
   // run control
   // ****************************************************************
   always_comb begin
      wr_ctrl = sfr_wr_i && (sfr_addr_i == cacm_pkg::CTRL_ADDR);
      wr_mode = sfr_wr_i && (sfr_addr_i == cacm_pkg::MODE_ADDR);
      wctrl   = cacm_pkg::cacm_ctrl_t'(sfr_wdata_i);
      wmode   = cacm_pkg::cacm_mode_t'(sfr_wdata_i);
      // watchdog overrides a stopped run bit without changing what it reads
      run     = ctrl_ff.run | mode_ff.wd_enable;
      suspend = mode_ff.idle_suspend & cpu_idle_i;
      active  = run & ~suspend;
      step    = active & tick;
   end

   // ****************************************************************
   // control register and counter
   // ****************************************************************
   always_comb begin
      nxt_ctrl  = ctrl_ff;
      nxt_count = count_ff;
      if (step) begin
         nxt_count = count_ff + 16'h0001;
      end
      if (wr_ctrl) begin
         // flags take the written value, so only software clears them
         nxt_ctrl.ovf      = wctrl.ovf;
         nxt_ctrl.run      = wctrl.run;
         nxt_ctrl.mod_flag = wctrl.mod_flag;
      end
      nxt_ctrl.rsv = 3'h0;
      // hardware set wins over a clear written in the same cycle
      if (step && (count_ff == cacm_pkg::CNT_MAX)) begin
         nxt_ctrl.ovf = 1'b1;
      end
      // module events are lost while the array is suspended
      if (~suspend) begin
         nxt_ctrl.mod_flag = nxt_ctrl.mod_flag | module_event_i;
      end
   end

   // ****************************************************************
   // mode register
   // ****************************************************************
   always_comb begin
      nxt_mode = mode_ff;
      if (wr_mode) begin
         if (mode_ff.wd_enable) begin
            // only the enable itself may change; lock holds it on
            if (!mode_ff.wd_lock) begin
               nxt_mode.wd_enable = wmode.wd_enable;
            end
         end else begin
            nxt_mode.idle_suspend = wmode.idle_suspend;
            nxt_mode.timebase     = wmode.timebase;
            nxt_mode.ovf_irq_en   = wmode.ovf_irq_en;
            nxt_mode.wd_lock      = wmode.wd_lock;
            // setting the lock also turns the watchdog on
            nxt_mode.wd_enable    = wmode.wd_enable | wmode.wd_lock;
         end
      end
      nxt_mode.rsv = 1'b0;
   end

   // ****************************************************************
   // watchdog trigger and read data
   // ****************************************************************
   always_comb begin
      nxt_wdrst = wr_ctrl && mode_ff.wd_enable
                  && sfr_wdata_i[cacm_pkg::CTRL_MOD2_BIT];
      nxt_rdata = rdata_ff;
      if (sfr_rd_i) begin
         if (sfr_addr_i == cacm_pkg::CTRL_ADDR) begin
            nxt_rdata = ctrl_ff;
         end else if (sfr_addr_i == cacm_pkg::MODE_ADDR) begin
            nxt_rdata = mode_ff;
         end else begin
            nxt_rdata = cacm_pkg::RDATA_NONE;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_ff  <= cacm_pkg::cacm_ctrl_t'(cacm_pkg::CTRL_RESET);
         mode_ff  <= cacm_pkg::cacm_mode_t'(cacm_pkg::MODE_RESET);
         count_ff <= 16'h0000;
         rdata_ff <= cacm_pkg::RDATA_NONE;
         wdrst_ff <= 1'b0;
      end else begin
         ctrl_ff  <= nxt_ctrl;
         mode_ff  <= nxt_mode;
         count_ff <= nxt_count;
         rdata_ff <= nxt_rdata;
         wdrst_ff <= nxt_wdrst;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   always_comb begin
      irq_o = (ctrl_ff.ovf & mode_ff.ovf_irq_en)
              | (|(ctrl_ff.mod_flag & module_irq_enable_i));
   end

   assign sfr_rdata_o        = rdata_ff;
   assign watchdog_reset_o   = wdrst_ff;
   assign module2_watchdog_o = mode_ff.wd_enable;
   assign counter_active_o   = active;
   assign counter_tick_o     = step;
   assign count_o            = count_ff;

endmodule

// *** tb/cacm_sva.sv ***
`timescale 1ns/100ps
module cacm_sva (
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   input  wire logic [7:0]  sfr_addr_i,
   input  wire logic        sfr_wr_i,
   input  wire logic        sfr_rd_i,
   input  wire logic [7:0]  sfr_wdata_i,
   input  wire logic [7:0]  sfr_rdata_o,
   input  wire logic        watchdog_reset_o,
   input  wire logic        module2_watchdog_o,
   input  wire logic        counter_active_o,
   input  wire logic        counter_tick_o,
   input  wire logic [15:0] count_o
);
   // ****************************************************************
   // checks at the ports
   // ****************************************************************
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   a_wdr_fire: assert property (sfr_wr_i && sfr_addr_i == cacm_pkg::CTRL_ADDR
      && sfr_wdata_i[2] && module2_watchdog_o |=> watchdog_reset_o) else $error("wd reset missing");
   a_wdr_cause: assert property (watchdog_reset_o |-> $past(sfr_wr_i) && $past(sfr_wdata_i[2])
      && $past(sfr_addr_i) == cacm_pkg::CTRL_ADDR) else $error("wd reset without cause");
   a_tick_incr: assert property (counter_tick_o |=> count_o == $past(count_o) + 16'h1)
      else $error("count did not step");
   a_count_hold: assert property (!counter_tick_o |=> $stable(count_o))
      else $error("count moved without tick");
   a_tick_active: assert property (counter_tick_o |-> counter_active_o)
      else $error("tick while inactive");
   a_count_wrap: assert property (count_o == 16'hffff && counter_tick_o |=> count_o == 16'h0)
      else $error("count did not wrap");
   a_ctrl_rsv: assert property (sfr_rd_i && sfr_addr_i == cacm_pkg::CTRL_ADDR
      |=> sfr_rdata_o[5:3] == 3'h0) else $error("ctrl unused bits set");
   a_mode_rsv: assert property (sfr_rd_i && sfr_addr_i == cacm_pkg::MODE_ADDR
      |=> sfr_rdata_o[4] == 1'b0) else $error("mode unused bit set");
   a_mode_wde: assert property (sfr_rd_i && sfr_addr_i == cacm_pkg::MODE_ADDR
      |=> sfr_rdata_o[6] == $past(module2_watchdog_o)) else $error("wd enable mismatch");

   c_wdr: cover property (watchdog_reset_o);
   c_wrap: cover property (count_o == 16'hffff && counter_tick_o);
   c_mode_rd: cover property (sfr_rd_i && sfr_addr_i == cacm_pkg::MODE_ADDR);
endmodule

bind cacm_top cacm_sva u_cacm_sva (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .sfr_addr_i(sfr_addr_i),
   .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
   .sfr_rdata_o(sfr_rdata_o), .watchdog_reset_o(watchdog_reset_o),
   .module2_watchdog_o(module2_watchdog_o), .counter_active_o(counter_active_o),
   .counter_tick_o(counter_tick_o), .count_o(count_o));

// *** tb/cacm_top_tb.sv ***
`timescale 1ns/100ps
module cacm_top_tb;
   logic        mclk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic [7:0]  sfr_addr_i = 8'h00;
   logic        sfr_wr_i = 1'b0;
   logic        sfr_rd_i = 1'b0;
   logic [7:0]  sfr_wdata_i = 8'h00;
   logic        cpu_idle_i = 1'b0;
   logic        timer0_ovf_i = 1'b0;
   logic        external_count_input_i = 1'b1;
   logic        ext_clk_i = 1'b0;
   logic [2:0]  module_event_i = 3'h0;
   logic [2:0]  module_irq_enable_i = 3'h0;
   logic [7:0]  sfr_rdata_o;
   logic        irq_o;
   logic        watchdog_reset_o;
   logic        module2_watchdog_o;
   logic        counter_active_o;
   logic        counter_tick_o;
   logic [15:0] count_o;
   int          errors = 0;
   int          n_compared = 0;
   int          cyc = 0;
   int          b;
   logic [2:0]  en;

   cacm_top u_cacm_top (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .sfr_addr_i(sfr_addr_i),
      .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
      .sfr_rdata_o(sfr_rdata_o), .cpu_idle_i(cpu_idle_i), .timer0_ovf_i(timer0_ovf_i),
      .external_count_input_i(external_count_input_i), .ext_clk_i(ext_clk_i),
      .module_event_i(module_event_i),
      .module_irq_enable_i(module_irq_enable_i), .irq_o(irq_o),
      .watchdog_reset_o(watchdog_reset_o), .module2_watchdog_o(module2_watchdog_o),
      .counter_active_o(counter_active_o), .counter_tick_o(counter_tick_o), .count_o(count_o));

   initial begin
      forever #12.5 mclk_i = ~mclk_i;
   end

   // ****************************************************************
   // helpers
   // ****************************************************************
   task automatic report_and_stop();
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk_i);
      sfr_addr_i = a;
      sfr_wdata_i = d;
      sfr_wr_i = 1'b1;
      @(negedge mclk_i);
      sfr_wr_i = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge mclk_i);
      sfr_addr_i = a;
      sfr_rd_i = 1'b1;
      @(negedge mclk_i);
      sfr_rd_i = 1'b0;
      chk(sfr_rdata_o, e);
   endtask

   // expected ticks in a window of n clocks per timebase, for the pin sources driven below
   function automatic int exp_ticks(input int sel, input int n);
      case (sel)
         0: return n / 12;
         1: return n / 4;
         2: return n / 6;
         3: return n / 8;
         4: return n;
         5: return n / 32;
         default: return 0;
      endcase
   endfunction

   // free-running sources; the count input falls every 8 clocks, inside the quarter-rate limit
   always @(negedge mclk_i) begin
      timer0_ovf_i           <= (cyc % 6 == 0);
      external_count_input_i <= ~cyc[2];
      ext_clk_i              <= cyc[1];
   end

   task automatic ticks(input int n, input int e);
      int k;
      k = 0;
      repeat (n) begin
         @(negedge mclk_i);
         if (counter_tick_o === 1'b1) k++;
      end
      chk(k[15:0], e[15:0]);
   endtask

   // the overflow walk alone needs about 65400 cycles
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 80000) begin
         errors++;
         report_and_stop();
      end
   end

   // ****************************************************************
   // scenarios
   // ****************************************************************
   initial begin
      void'($urandom(86));
      repeat (4) @(negedge mclk_i);
      rst_n_i = 1'b1;
      repeat (3) @(negedge mclk_i);
      rd(cacm_pkg::CTRL_ADDR, 8'h00);
      rd(cacm_pkg::MODE_ADDR, 8'h40);
      rd(8'h00, 8'h00);
      chk(module2_watchdog_o, 1'b1);
      // all ones keeps the enable on, so every other bit must be refused
      wr(cacm_pkg::MODE_ADDR, 8'hff);
      rd(cacm_pkg::MODE_ADDR, 8'h40);
      wr(cacm_pkg::CTRL_ADDR, 8'h04);
      chk(watchdog_reset_o, 1'b1);
      @(negedge mclk_i);
      chk(watchdog_reset_o, 1'b0);
      wr(cacm_pkg::MODE_ADDR, 8'h00);
      rd(cacm_pkg::MODE_ADDR, 8'h00);
      chk(module2_watchdog_o, 1'b0);
      wr(cacm_pkg::CTRL_ADDR, 8'h38);
      rd(cacm_pkg::CTRL_ADDR, 8'h00);
      wr(cacm_pkg::MODE_ADDR, 8'h10);
      rd(cacm_pkg::MODE_ADDR, 8'h00);
      wr(cacm_pkg::CTRL_ADDR, 8'h40);
      for (int i = 0; i < 7; i++) begin
         wr(cacm_pkg::MODE_ADDR, {4'h0, 3'(i), 1'b0});
         ticks(96, exp_ticks(i, 96));
      end
      wr(cacm_pkg::MODE_ADDR, 8'h88);
      cpu_idle_i = 1'b1;
      ticks(10, 0);
      chk(counter_active_o, 1'b0);
      cpu_idle_i = 1'b0;
      ticks(10, 10);
      wr(cacm_pkg::CTRL_ADDR, 8'h00);
      ticks(10, 0);
      repeat (20) begin
         b = $urandom % 3;
         en = 3'($urandom);
         wr(cacm_pkg::CTRL_ADDR, 8'h00);
         module_irq_enable_i = en;
         module_event_i = 3'h1 << b;
         @(negedge mclk_i);
         module_event_i = 3'h0;
         repeat (2) @(negedge mclk_i);
         rd(cacm_pkg::CTRL_ADDR, 8'h1 << b);
         chk(irq_o, en[b]);
      end
      wr(cacm_pkg::CTRL_ADDR, 8'h00);
      wr(cacm_pkg::MODE_ADDR, 8'h09);
      wr(cacm_pkg::CTRL_ADDR, 8'h40);
      while (count_o !== 16'hffff) @(negedge mclk_i);
      @(negedge mclk_i);
      chk(count_o, 16'h0000);
      rd(cacm_pkg::CTRL_ADDR, 8'hc0);
      chk(irq_o, 1'b1);
      repeat (20) @(negedge mclk_i);
      rd(cacm_pkg::CTRL_ADDR, 8'hc0);
      wr(cacm_pkg::MODE_ADDR, 8'h08);
      chk(irq_o, 1'b0);
      wr(cacm_pkg::MODE_ADDR, 8'h20);
      rd(cacm_pkg::MODE_ADDR, 8'h60);
      wr(cacm_pkg::MODE_ADDR, 8'h00);
      rd(cacm_pkg::MODE_ADDR, 8'h60);
      chk(module2_watchdog_o, 1'b1);
      wr(cacm_pkg::CTRL_ADDR, 8'h00);
      chk(counter_active_o, 1'b1);
      rd(cacm_pkg::CTRL_ADDR, 8'h00);
      // a second reset must drop the lock and bring the watchdog back on
      rst_n_i = 1'b0;
      repeat (2) @(negedge mclk_i);
      chk(module2_watchdog_o, 1'b1);
      rst_n_i = 1'b1;
      repeat (3) @(negedge mclk_i);
      rd(cacm_pkg::MODE_ADDR, 8'h40);
      wr(cacm_pkg::MODE_ADDR, 8'h00);
      rd(cacm_pkg::MODE_ADDR, 8'h00);
      report_and_stop();
   end
endmodule
